/* File: design/dct_channel.sv */
/*
  one 16-bit timer channel used as a delay counter, with its unit
  prescaler and unit enable; registers on a plain strobe port.
  assumes one 40 MHz clock, a synchronous reset and an asynchronous pin.
*/
// Decided for this implementation: the placing of the registers and strobed register access.
// Behaviour
// RQ1 - pin valid edge starts down-count, then interrupt
// RQ2 - software start while enabled acts as trigger
// RQ3 - interval is count period times compare plus one
// RQ4 - start write sets enable, waits for edge
// RQ5 - trigger loads compare, decrement each count clock
// RQ6 - zero gives interrupt, halts until next trigger
// RQ7 - new compare value used only at next load
// RQ8 - start bit clears itself
// RQ9 - stop write clears enable, count holds
// RQ10 - one-count operation only with mode 100B
// RQ11 - mode bit: retrigger during count ignored/accepted
// RQ12 - edge select: falling, rising, both; 11B prohibited
// RQ13 - trigger select 001B picks pin edge
// RQ14 - split bit picks 8-bit on channels 1,3
// RQ15 - clock select: CK0, CK1; CK2/CK3 only 8-bit
// RQ16 - count source 0 uses operation clock
// RQ17 - software keeps master select zero here
// RQ18 - software keeps timer output disabled here
// RQ19 - unit disabled: clock stopped, writes ignored
// RQ20 - unit disable returns everything to reset
// RQ21 - count always readable, status never updated
// RQ22 - pin sampled on operation clock before edges
// RQ23 - accepted retrigger reloads compare, restarts count
// RQ24 - interrupt one operation clock wide at zero
`include "dct_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module dct_channel #(
  parameter int CHAN_NUM = 1
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        event_input_pin,
  output logic             chan_timer_irq,
  output logic             chan_enable_status,
  output logic             timer_out_pin
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration check: the unit has channels 0 to 3
  if (CHAN_NUM < 0 || CHAN_NUM > 3) begin : g_bad_chan
    $error("dct_channel: CHAN_NUM must be 0 to 3");
  end

  // only channels 1 and 3 own the split control
  localparam logic SPLIT_OK = (CHAN_NUM == 1) || (CHAN_NUM == 3);

  ////////////////////////////////////////////////////////////////////////
  // functions
  // prescaler tap: fires once every 2**div cycles
  function automatic logic ck_tick(input logic [15:0] cnt,
                                   input logic [3:0]  div);
    logic [15:0] mask;
    mask = (16'h0001 << div) - 16'h0001;
    return (cnt & mask) == mask;
  endfunction

  // counter width mask for 8- or 16-bit operation
  function automatic logic [15:0] wmask(input logic w8);
    return w8 ? `DCT_MASK_8 : `DCT_MASK_16;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state and decode
  dct_pkg::dct_state_s s_q;
  dct_pkg::dct_state_s s_d;

  logic        wr_start;
  logic        wr_stop;
  logic        w8;
  logic [15:0] msk;
  logic [3:0]  ck;
  logic        op_tick;
  logic        pin_edge;
  logic        mode_ok;
  logic        trig;
  logic        cnt_tick;
  logic        do_load;
  logic        do_dec;
  logic [15:0] cnt_nx;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic; unit disable comes after all but the unit enable write, so it overrides them
  always_comb begin
    s_d       = s_q;
    s_d.rdata = `DCT_RST_WORD;
    wr_start  = reg_wr && (reg_addr == `DCT_OFF_START) && reg_wdata[0];
    wr_stop   = reg_wr && (reg_addr == `DCT_OFF_STOP) && reg_wdata[0];
    w8        = SPLIT_OK && s_q.mode[`DCT_SPLIT];              // see RQ14
    msk       = wmask(w8);
    mode_ok   = s_q.mode[`DCT_MD_HI:`DCT_MD_LO] == `DCT_MD_ONECNT; // see RQ10
    do_load   = 1'b0;
    do_dec    = 1'b0;
    cnt_nx    = `DCT_RST_WORD;

    // prescaler runs only with the unit clock supplied
    s_d.psc_cnt = s_q.psc_cnt + 16'h0001;                      // see RQ19
    for (int k = 0; k < 4; k++) begin
      ck[k] = ck_tick(s_q.psc_cnt, s_q.psc[4*k +: `DCT_PSC_W]);
    end

    // operation clock select; CK2/CK3 fall back to CK0 when not allowed
    case (s_q.mode[`DCT_CKS_HI:`DCT_CKS_LO])                  // see RQ15
      `DCT_CKS_0: op_tick = ck[0];
      `DCT_CKS_1: op_tick = ck[1];
      `DCT_CKS_2: op_tick = w8 ? ck[2] : ck[0];
      `DCT_CKS_3: op_tick = w8 ? ck[3] : ck[0];
      default:    op_tick = ck[0];
    endcase

    // pin crossing, then resample on the operation clock
    s_d.pin_s1 = event_input_pin;
    s_d.pin_s2 = s_q.pin_s1;
    if (op_tick) begin
      s_d.samp = s_q.pin_s2;                                   // see RQ22
    end

    // valid edge; the prohibited code never fires
    case (s_q.mode[`DCT_CIS_HI:`DCT_CIS_LO])                  // see RQ12
      `DCT_CIS_FALL: pin_edge = op_tick && s_q.samp && !s_q.pin_s2;
      `DCT_CIS_RISE: pin_edge = op_tick && !s_q.samp && s_q.pin_s2;
      `DCT_CIS_BOTH: pin_edge = op_tick && (s_q.samp != s_q.pin_s2);
      default:       pin_edge = 1'b0;
    endcase

    // count clock: operation clock, or the valid edge when source is 1
    cnt_tick = s_q.mode[`DCT_CCS] ? pin_edge : op_tick;        // see RQ16

    // start triggers: pin edge when selected, or a software start
    trig = mode_ok && s_q.en && (wr_start ||                   // see RQ2
           (pin_edge &&
            s_q.mode[`DCT_STS_HI:`DCT_STS_LO] == `DCT_STS_PIN)); // see RQ1, RQ13

    // interrupt lasts until the next operation clock
    if (op_tick) begin
      s_d.irq = 1'b0;                                          // see RQ24
    end

    // channel sequencing
    case (s_q.st)
      dct_pkg::DCT_IDLE: begin
        s_d.load_pend = 1'b0;
      end
      dct_pkg::DCT_WAIT: begin
        if (trig) begin
          s_d.load_pend = 1'b1;                                // see RQ5
          s_d.st        = dct_pkg::DCT_COUNT;
        end
      end
      dct_pkg::DCT_COUNT: begin
        // a stop in the same cycle wins: the count freezes where it stands
        // and no interrupt is raised from a value that never got stored
        if (cnt_tick && mode_ok && !wr_stop) begin               // see RQ9
          // first tick after a trigger loads, so the span is value plus one
          if (s_q.load_pend) begin
            do_load = 1'b1;
            cnt_nx  = s_q.cmp & msk;                           // see RQ3, RQ7
          end else begin
            do_dec = 1'b1;
            cnt_nx = (s_q.cnt - 16'h0001) & msk;               // see RQ5
          end
          s_d.cnt       = cnt_nx;
          s_d.load_pend = 1'b0;
          if (cnt_nx == `DCT_RST_WORD) begin
            s_d.irq = 1'b1;                                    // see RQ6
            s_d.st  = dct_pkg::DCT_WAIT;
          end
        end
        // a later trigger restarts only when retrigger is enabled
        if (trig && s_q.mode[`DCT_MD_RETRG]) begin             // see RQ11
          s_d.load_pend = 1'b1;                                // see RQ23
          s_d.st        = dct_pkg::DCT_COUNT;
        end
      end
      default: begin
        s_d.st = dct_pkg::DCT_IDLE;
      end
    endcase

    // start while stopped enables and arms; start bit itself is not stored
    if (wr_start && !s_q.en) begin                             // see RQ8
      s_d.en        = 1'b1;                                    // see RQ4
      s_d.st        = dct_pkg::DCT_WAIT;
      s_d.load_pend = 1'b0;
    end
    // stop leaves the count frozen where it is
    if (wr_stop) begin
      s_d.en        = 1'b0;                                    // see RQ9
      s_d.st        = dct_pkg::DCT_IDLE;
      s_d.load_pend = 1'b0;
    end

    // configuration writes; mode is not protected while counting
    if (reg_wr) begin
      case (reg_addr)
        `DCT_OFF_PSC:  s_d.psc  = reg_wdata;
        `DCT_OFF_MODE: s_d.mode = reg_wdata;
        `DCT_OFF_CMP:  s_d.cmp  = reg_wdata;                   // see RQ7
        `DCT_OFF_TOE:  s_d.toe  = reg_wdata[0];                // see RQ18
        default: ;
      endcase
    end

    // read data, valid only in the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `DCT_OFF_UNIT:   s_d.rdata = {15'h0000, s_q.unit_en};
        `DCT_OFF_PSC:    s_d.rdata = s_q.psc;
        `DCT_OFF_MODE:   s_d.rdata = s_q.mode;
        `DCT_OFF_CMP:    s_d.rdata = s_q.cmp;
        `DCT_OFF_COUNT:  s_d.rdata = s_q.cnt;                  // see RQ21
        `DCT_OFF_ENSTAT: s_d.rdata = {15'h0000, s_q.en};
        `DCT_OFF_TOE:    s_d.rdata = {15'h0000, s_q.toe};
        default:         s_d.rdata = `DCT_RST_WORD;            // status stays 0
      endcase
    end

    // unit disabled: everything but the unit enable, the pin synchronizer and the read data returns to reset
    if (!s_q.unit_en) begin                                    // see RQ19, RQ20
      s_d.psc       = `DCT_RST_WORD;
      s_d.psc_cnt   = `DCT_RST_WORD;
      s_d.mode      = `DCT_RST_WORD;
      s_d.cmp       = `DCT_RST_WORD;
      s_d.cnt       = `DCT_RST_WORD;
      s_d.toe       = 1'b0;
      s_d.en        = 1'b0;
      s_d.st        = dct_pkg::DCT_IDLE;
      s_d.load_pend = 1'b0;
      s_d.irq       = 1'b0;
      s_d.samp      = 1'b0;
    end
    // the unit enable itself is always writable
    if (reg_wr && reg_addr == `DCT_OFF_UNIT) begin
      s_d.unit_en = reg_wdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; the output pin is not used by this mode
  assign reg_rdata          = s_q.rdata;
  assign chan_timer_irq     = s_q.irq;
  assign chan_enable_status = s_q.en;
  assign timer_out_pin      = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // interrupt rises only with the count at zero; a retrigger may rearm at once
  chk_irq_at_zero: assert property ( // see RQ6
    $rose(s_q.irq) |-> s_q.cnt == 16'h0000 &&
      (s_q.st == dct_pkg::DCT_WAIT || s_q.load_pend))
    else $error("interrupt without zero count");

  // start write while stopped enables and waits
  chk_start_enables: assert property ( // see RQ4
    wr_start && !s_q.en && s_q.unit_en |=>
      s_q.en && s_q.st == dct_pkg::DCT_WAIT)
    else $error("start did not enable channel");

  // stop clears enable and freezes count
  chk_stop_holds: assert property ( // see RQ9
    wr_stop && s_q.unit_en |=> !s_q.en && s_q.cnt == $past(s_q.cnt)
      ##1 s_q.cnt == $past(s_q.cnt, 2))
    else $error("stop did not freeze count");

  // load takes the compare value of that moment
  chk_load_value: assert property ( // see RQ5
    do_load && s_q.unit_en |=> s_q.cnt == ($past(s_q.cmp) & $past(msk)))
    else $error("bad load value");

  // each count clock takes one off
  chk_decrement: assert property ( // see RQ5
    do_dec && s_q.unit_en |=> s_q.cnt == (($past(s_q.cnt) - 16'h0001) & $past(msk)))
    else $error("bad decrement");

  // unit disable clears the channel
  chk_unit_reset: assert property ( // see RQ20
    !s_q.unit_en |=> s_q.cnt == 16'h0000 && !s_q.en && !s_q.irq)
    else $error("unit disable left state");

  // writes while disabled have no effect
  chk_write_ignored: assert property ( // see RQ19
    !s_q.unit_en && reg_wr && reg_addr == `DCT_OFF_CMP |=> s_q.cmp == 16'h0000)
    else $error("write taken while disabled");

  // retrigger ignored when the mode bit is 0
  chk_no_retrigger: assert property ( // see RQ11
    s_q.st == dct_pkg::DCT_COUNT && !s_q.load_pend && trig &&
    !s_q.mode[`DCT_MD_RETRG] |=> !s_q.load_pend)
    else $error("retrigger accepted while disabled");

  // waiting channel holds its count
  chk_wait_halts: assert property ( // see RQ6
    s_q.st == dct_pkg::DCT_WAIT && !trig && s_q.unit_en && !wr_stop |=>
      $stable(s_q.cnt))
    else $error("count moved while waiting");

  // count register read returns the count
  chk_read_count: assert property ( // see RQ21
    reg_rd && reg_addr == `DCT_OFF_COUNT |=> reg_rdata == $past(s_q.cnt))
    else $error("count read mismatch");

  // wrong mode never counts
  chk_mode_gate: assert property ( // see RQ10
    !mode_ok && s_q.st == dct_pkg::DCT_COUNT |=> $stable(s_q.cnt) || !s_q.unit_en)
    else $error("counted outside one-count mode");

  // a trigger while waiting arms the load at the next count clock
  chk_trig_arms: assert property ( // see RQ1
    trig && s_q.st == dct_pkg::DCT_WAIT && s_q.unit_en && !wr_stop |=>
      s_q.st == dct_pkg::DCT_COUNT && s_q.load_pend)
    else $error("trigger did not arm the count");

  // accepted retrigger rearms the load mid-count
  chk_retrig_reload: assert property ( // see RQ23
    trig && s_q.st == dct_pkg::DCT_COUNT && s_q.mode[`DCT_MD_RETRG] &&
      s_q.unit_en && !wr_stop |=> s_q.st == dct_pkg::DCT_COUNT && s_q.load_pend)
    else $error("retrigger did not rearm");

  // interrupt stands until the next operation clock
  chk_irq_holds: assert property ( // see RQ24
    s_q.irq && !op_tick && s_q.unit_en |=> s_q.irq)
    else $error("interrupt dropped early");

  // and is gone after it unless a new zero is reached
  chk_irq_ends: assert property ( // see RQ24
    s_q.irq && op_tick && s_q.st != dct_pkg::DCT_COUNT |=> !s_q.irq)
    else $error("interrupt longer than one operation clock");

  // a stop never lets the interrupt through
  chk_stop_no_irq: assert property ( // see RQ9
    wr_stop && s_q.unit_en |=> !$rose(s_q.irq))
    else $error("interrupt raised by stop cycle");

  // start is a trigger only: it never reads back as 1
  chk_start_clear: assert property ( // see RQ8
    reg_rd && reg_addr == `DCT_OFF_START |=> reg_rdata == 16'h0000)
    else $error("start bit read back set");

  // status is never updated in this mode
  chk_status_zero: assert property ( // see RQ21
    reg_rd && reg_addr == `DCT_OFF_STAT |=> reg_rdata == 16'h0000)
    else $error("status register not zero");

  // main scenarios the bench should reach
  cov_irq: cover property ($rose(s_q.irq));
  cov_sw_trig: cover property (wr_start && s_q.en && s_q.st == dct_pkg::DCT_WAIT);
  cov_retrig: cover property (trig && s_q.st == dct_pkg::DCT_COUNT &&
                              s_q.mode[`DCT_MD_RETRG]);
  cov_split: cover property (do_load && w8);
  cov_stop_count: cover property (wr_stop && s_q.st == dct_pkg::DCT_COUNT);

endmodule

`default_nettype wire

/* File: design/dct_consts.svh */
/*
  register offsets, field positions, codes and reset values of the
  delay counter channel; assumes a 4-bit word address on the reg port.
*/
`ifndef DCT_CONSTS_SVH
`define DCT_CONSTS_SVH
////////////////////////////////////////////////////////////////////////
// word offsets on the register port
`define DCT_OFF_UNIT   4'h0
`define DCT_OFF_PSC    4'h1
`define DCT_OFF_MODE   4'h2
`define DCT_OFF_CMP    4'h3
`define DCT_OFF_COUNT  4'h4
`define DCT_OFF_START  4'h5
`define DCT_OFF_STOP   4'h6
`define DCT_OFF_ENSTAT 4'h7
`define DCT_OFF_TOE    4'h8
`define DCT_OFF_STAT   4'h9
////////////////////////////////////////////////////////////////////////
// mode register field positions
`define DCT_CKS_HI   15
`define DCT_CKS_LO   14
`define DCT_CCS      12
`define DCT_SPLIT    11
`define DCT_STS_HI   10
`define DCT_STS_LO   8
`define DCT_CIS_HI   7
`define DCT_CIS_LO   6
`define DCT_MD_HI    3
`define DCT_MD_LO    1
`define DCT_MD_RETRG 0
`define DCT_PSC_W    4
////////////////////////////////////////////////////////////////////////
// field codes
`define DCT_MD_ONECNT 3'h4
`define DCT_STS_PIN   3'h1
`define DCT_CIS_FALL  2'h0
`define DCT_CIS_RISE  2'h1
`define DCT_CIS_BOTH  2'h2
`define DCT_CKS_0     2'h0
`define DCT_CKS_2     2'h1
`define DCT_CKS_1     2'h2
`define DCT_CKS_3     2'h3
////////////////////////////////////////////////////////////////////////
// reset values and masks
`define DCT_RST_WORD  16'h0000
`define DCT_MASK_16   16'hFFFF
`define DCT_MASK_8    16'h00FF
`endif

/* File: design/dct_pkg.sv */
/*
  types of the delay counter channel: channel state and the state record;
  takes no numbers from dct_consts.svh; the state codes are given here.
*/
package dct_pkg;
  // channel sequencing
  typedef enum logic [1:0] {
    DCT_IDLE  = 2'b00,
    DCT_WAIT  = 2'b01,
    DCT_COUNT = 2'b10
  } dct_state_e;

  typedef logic [15:0] dct_word_t;

  // every flip-flop of the channel
  typedef struct packed {
    logic       unit_en;
    dct_word_t  psc;
    dct_word_t  psc_cnt;
    dct_word_t  mode;
    dct_word_t  cmp;
    dct_word_t  cnt;
    logic       toe;
    logic       en;
    dct_state_e st;
    logic       load_pend;
    logic       irq;
    logic       pin_s1;
    logic       pin_s2;
    logic       samp;
    dct_word_t  rdata;
  } dct_state_s;
endpackage

/* File: test/dct_event_src.sv */
/*
  model of the event source at the channel's timer input pin.
  assumes the bench calls pulse from its main thread; pin idles low.
*/
`timescale 1ns/100ps
`default_nettype none
module dct_event_src (
  input  wire logic core_clk,
  output var logic  event_input_pin
);
  initial event_input_pin = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // pulse of given width; edges land 7 ns off the clock, as a free pin would
  task automatic pulse(input int width);
    @(posedge core_clk);
    #7 event_input_pin = 1'b1;
    repeat (width) @(posedge core_clk);
    #7 event_input_pin = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_delay_counter_timer_channel.sv */
/*
  self-checking bench of the delay counter channel: a table of timed
  software starts, then pin edges, retrigger, stop and unit disable.
  assumes dct_channel, dct_consts.svh and the event source model.
*/
`include "dct_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_delay_counter_timer_channel;
  localparam logic [15:0] M = 16'h0108; // pin start, one-count, bit 11 kept 0
  typedef struct {logic [15:0] mode, psc, cmp; int lo, hi, p;} dct_row_s;
  // mode, prescaler, compare, irq delay window after the start, irq width
  dct_row_s rows[7] = '{
    '{M, 16'h0000, 16'h0000, 1, 1, 1}, '{M, 16'h0000, 16'h0002, 3, 3, 1},
    '{M, 16'h0000, 16'h00FF, 256, 256, 1}, '{M, 16'h0001, 16'h0003, 7, 8, 2},
    '{M | 16'hC000, 16'h3000, 16'h0003, 4, 4, 1},
    '{M | 16'h4800, 16'h0100, 16'h0103, 7, 8, 2},
    '{M | 16'h8000, 16'h0020, 16'h0001, 5, 8, 4}};
  logic [15:0] emode[5] = '{M, M | 16'h0040, M | 16'h0080, M | 16'h00C0, 16'h0008};
  int          epuls[5] = '{1, 1, 2, 0, 0};
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, rd_val, v1;
  logic        event_input_pin, chan_timer_irq, chan_enable_status, timer_out_pin;
  logic        irq_prev = 1'b0;
  int          err_total = 0, total_checks = 0, cyc = 0, irq_cnt = 0, n, w;

  ////////////////////////////////////////////////////////////////////////
  dct_channel #(.CHAN_NUM(1)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .event_input_pin(event_input_pin),
    .chan_timer_irq(chan_timer_irq), .chan_enable_status(chan_enable_status),
    .timer_out_pin(timer_out_pin));
  dct_event_src SRC (.core_clk(core_clk), .event_input_pin(event_input_pin));

  // 25 ns clock
  initial forever #12.5 core_clk = ~core_clk;

  // irq pulse count and a run ceiling well above the thousand or so cycles used
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    irq_prev <= chan_timer_irq;
    if (chan_timer_irq === 1'b1 && irq_prev !== 1'b1)
      irq_cnt <= irq_cnt + 1;
    if (cyc == 10000) begin
      err_total++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic range_chk(input int got, lo, hi, input string what);
    total_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("mismatch at %0t: %s got %0d expected %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // cycles from the taking edge of the last strobe to the irq
  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      #1 k++;
    end while (chan_timer_irq !== 1'b1 && k < 2000);
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    wr(`DCT_OFF_MODE, M);
    wr(`DCT_OFF_UNIT, 16'h0001);
    rd(`DCT_OFF_MODE);
    check(rd_val, 16'h0000, "mode write with unit off");
    check(chan_enable_status, 16'h0000, "enable after reset");
    wr(`DCT_OFF_TOE, 16'h0000);
    wr(`DCT_OFF_START, 16'h0001);
    wr(`DCT_OFF_START, 16'h0001);
    repeat (20) @(posedge core_clk);
    check(irq_cnt, 0, "irq outside one-count mode");
    check(chan_enable_status, 16'h0001, "enable after start");
    rd(`DCT_OFF_START);
    check(rd_val, 16'h0000, "start bit readback");
    rd(`DCT_OFF_STAT);
    check(rd_val, 16'h0000, "status register");
    check(timer_out_pin, 16'h0000, "timer output");
    // software starts across compare, prescaler, clock select and split
    foreach (rows[i]) begin
      wr(`DCT_OFF_PSC, rows[i].psc);
      wr(`DCT_OFF_MODE, rows[i].mode);
      wr(`DCT_OFF_CMP, rows[i].cmp);
      wr(`DCT_OFF_START, 16'h0001);
      wait_irq(n);
      range_chk(n, rows[i].lo, rows[i].hi, "start to irq");
      w = 0;
      while (chan_timer_irq === 1'b1 && w < 100) begin
        @(posedge core_clk);
        #1 w++;
      end
      range_chk(w, rows[i].p, rows[i].p, "irq width");
      rd(`DCT_OFF_COUNT);
      check(rd_val, 16'h0000, "count after irq");
    end
    // pin edges per edge code and trigger source
    wr(`DCT_OFF_PSC, 16'h0000);
    wr(`DCT_OFF_CMP, 16'h0000);
    foreach (emode[i]) begin
      wr(`DCT_OFF_MODE, emode[i]);
      irq_cnt = 0;
      SRC.pulse(20);
      repeat (30) @(posedge core_clk);
      check(irq_cnt, epuls[i], "irqs per pin pulse");
    end
    // count source 1: software start, then both pin edges clock the count
    wr(`DCT_OFF_CMP, 16'h0001);
    wr(`DCT_OFF_MODE, 16'h1088);
    wr(`DCT_OFF_START, 16'h0001);
    irq_cnt = 0;
    repeat (20) @(posedge core_clk);
    check(irq_cnt, 0, "irq without pin edges");
    SRC.pulse(10);
    repeat (30) @(posedge core_clk);
    check(irq_cnt, 1, "irq after two pin edges");
    // second start mid-count, accepted then ignored
    wr(`DCT_OFF_CMP, 16'h000A);
    for (int r = 1; r >= 0; r--) begin
      wr(`DCT_OFF_MODE, M | 16'(r));
      wr(`DCT_OFF_START, 16'h0001);
      repeat (4) @(posedge core_clk);
      wr(`DCT_OFF_START, 16'h0001);
      wait_irq(n);
      range_chk(n, r ? 11 : 5, r ? 12 : 5, "irq after second start");
      repeat (5) @(posedge core_clk);
    end
    // compare rewrite mid-count waits for the next load
    wr(`DCT_OFF_START, 16'h0001);
    wr(`DCT_OFF_CMP, 16'h0003);
    wait_irq(n);
    range_chk(n, 9, 9, "irq with old compare");
    wr(`DCT_OFF_START, 16'h0001);
    wait_irq(n);
    range_chk(n, 4, 4, "irq with new compare");
    // count readable while running, then frozen by stop
    wr(`DCT_OFF_CMP, 16'h0028);
    wr(`DCT_OFF_START, 16'h0001);
    repeat (5) @(posedge core_clk);
    rd(`DCT_OFF_COUNT);
    v1 = rd_val;
    rd(`DCT_OFF_COUNT);
    check(rd_val, v1 - 16'h0002, "count decrements");
    // leaving one-count mode mid-count freezes the count until restored
    wr(`DCT_OFF_MODE, 16'h0000);
    rd(`DCT_OFF_COUNT);
    v1 = rd_val;
    rd(`DCT_OFF_COUNT);
    check(rd_val, v1, "count held outside one-count mode");
    wr(`DCT_OFF_MODE, M);
    irq_cnt = 0;
    wr(`DCT_OFF_STOP, 16'h0001);
    #1 check(chan_enable_status, 16'h0000, "enable after stop");
    rd(`DCT_OFF_COUNT);
    v1 = rd_val;
    repeat (60) @(posedge core_clk);
    rd(`DCT_OFF_COUNT);
    check(rd_val, v1, "count held after stop");
    check(irq_cnt, 0, "irq after stop");
    // unit disable clears every channel register
    wr(`DCT_OFF_UNIT, 16'h0000);
    wr(`DCT_OFF_CMP, 16'h0055);
    wr(`DCT_OFF_UNIT, 16'h0001);
    rd(`DCT_OFF_MODE);
    check(rd_val, 16'h0000, "mode after unit off");
    rd(`DCT_OFF_CMP);
    check(rd_val, 16'h0000, "compare after unit off");
    rd(`DCT_OFF_COUNT);
    check(rd_val, 16'h0000, "count after unit off");
    summarize();
  end
endmodule
`default_nettype wire
